/* File: hw/sclks_params.svh */
`ifndef SCLKS_PARAMS_SVH
`define SCLKS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SCLKS_OFS_SYS 4'h0
`define SCLKS_OFS_HSC 4'h4
`define SCLKS_OFS_XTC 4'h8
`define SCLKS_OFS_STAT 4'hC

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCLKS_SYS_SEL_LSB 5
`define SCLKS_SYS_SRC_BIT 2
`define SCLKS_SYS_HSKEEP_BIT 1
`define SCLKS_SYS_LSKEEP_BIT 0
`define SCLKS_HSC_FREQ_LSB 2
`define SCLKS_HSC_FLAG_BIT 1
`define SCLKS_HSC_EN_BIT 0
`define SCLKS_XTC_SP_BIT 2
`define SCLKS_XTC_FLAG_BIT 1
`define SCLKS_XTC_EN_BIT 0

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define SCLKS_SEL_RST 3'h0
`define SCLKS_SEL_SLOW 3'h7
`define SCLKS_FREQ_RST 2'h0
`define SCLKS_HSEN_RST 1'b1
`define SCLKS_FREQ_4M 2'h0
`define SCLKS_FREQ_8M 2'h1
`define SCLKS_FREQ_12M 2'h2
`define SCLKS_FREQ_4M_ALT 2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SCLKS_CLK_MHZ 50
`define SCLKS_HS_STAB_US 16
`define SCLKS_HS_STAB_CYC (`SCLKS_HS_STAB_US * `SCLKS_CLK_MHZ)
`define SCLKS_XT_SU_US 1000
`define SCLKS_XT_LP_US 2000
`define SCLKS_SWITCH_EDGES 4

`endif

/* File: hw/sclks_pkg.sv */
package sclks_pkg;

  typedef enum logic [2:0] {
    SCLKS_MODE_FAST,
    SCLKS_MODE_SLOW,
    SCLKS_MODE_IDLE_LOW_ONLY,
    SCLKS_MODE_IDLE_BOTH,
    SCLKS_MODE_IDLE_HS_ONLY,
    SCLKS_MODE_SLEEP
  } sclks_mode_t;

  typedef enum logic [1:0] {
    SCLKS_SW_RUN,
    SCLKS_SW_COUNT,
    SCLKS_SW_ALIGN
  } sclks_sw_t;

endpackage

/* File: hw/sclks_top.sv */
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "sclks_params.svh"

// Contract
// - 3-bit select picks high-speed clock, its /2../64 divisions, or low-speed.
// - Running CPU: codes 0-6 are fast mode, code 7 is slow mode.
// - Halted, hs keep-on clear, ls keep-on set: system and hs clocks stop.
// - One select bit picks crystal or low RC as the low-speed clock.
// - High-speed RC runs at 4, 8 or 12 MHz by a 2-bit field.
// - Enabling the crystal starts a start-up delay before it is usable.
// - Speed-up bit high gives speed-up start, low gives low-power mode.
// - Clearing speed-up after start keeps the crystal running uninterrupted; here xtal_speedup_en follows the bit at once, as at any other time.
// - Speed-up writes are ignored while the crystal drives the system clock.
// - Crystal works in either mode; low power only lengthens start-up.
// - Sleep or idle stops the CPU clock; peripheral clocks may continue.
// - In slow mode the high-speed oscillator follows its enable bit.
// - Crystal pins are free for general I/O when the crystal is unused.
// - Watchdog and time-base clocks come from the oscillators too.
// - Low-speed options are low RC about 32 kHz and crystal 32.768 kHz.
// - Enable or frequency change clears hs stable flag until settled.
// - Crystal enable clears the crystal stable flag until it settles.
// - Frequency field: 00 4 MHz, 01 8 MHz, 10 12 MHz, 11 4 MHz.
// - Switch completes after four current clock periods plus alignment.
module sclks_top
  import sclks_pkg::*;
#(
  parameter int XT_SU_CYC = `SCLKS_XT_SU_US * `SCLKS_CLK_MHZ,
  parameter int XT_LP_CYC = `SCLKS_XT_LP_US * `SCLKS_CLK_MHZ
) (
  // Clock, reset and enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // CPU and watchdog state
  input wire logic cpu_halt,
  input wire logic wdt_enable,
  // Oscillator outputs, asynchronous
  input wire logic hs_rc_osc,
  input wire logic low_rc_osc,
  input wire logic ext_low_xtal_osc,
  // Oscillator controls
  output logic hs_osc_en,
  output logic [1:0] hs_freq_code,
  output logic low_rc_en,
  output logic xtal_osc_en,
  output logic xtal_speedup_en,
  output logic xtal_pins_osc,
  // Generated clocks
  output logic system_clk,
  output logic high_speed_clk,
  output logic [5:0] hs_div_clk,
  output logic low_speed_clk,
  output logic wdt_clk,
  output logic tbase_clk
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic [2:0] sys_clk_sel_q;
  logic slow_src_sel_q, hs_keep_on_halt_q, ls_keep_on_halt_q;
  logic [1:0] hs_freq_sel_q;
  logic hs_enable_q, hs_stable_flag_q;
  logic xtal_enable_q, xtal_speedup_q, xtal_stable_flag_q;
  logic [2:0] hs_sync_q, lr_sync_q, xt_sync_q;
  logic [5:0] div_cnt_q;
  logic [2:0] cur_sel_q;
  logic cur_src_q, cur_prev_q, sys_run_q;
  logic [2:0] edge_cnt_q;
  sclks_sw_t sw_q;
  sclks_mode_t mode_q;
  logic hs_on_q, hs_on_prev_q, ls_on_q, lr_on_q;
  logic [9:0] hs_stab_cnt_q;
  logic [16:0] xt_stab_cnt_q;
  logic wr_ack, rd_ack;
  logic [6:0] hs_taps;
  logic cur_lvl, tgt_lvl, ls_lvl, xt_sys;
  logic [31:0] rd_mux;

  function automatic logic tap_level(input logic [2:0] sel,
                                     input logic src,
                                     input logic [6:0] taps,
                                     input logic xt,
                                     input logic lr);
    if (sel == `SCLKS_SEL_SLOW) begin
      return src ? xt : lr;
    end
    return taps[sel];
  endfunction

  // --------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------
  // One wait cycle per access; the access completes while waitrequest is
  // low, so a held request is never taken twice.
  assign wr_ack = avs_write && !avs_waitrequest;
  assign rd_ack = avs_read && !avs_waitrequest;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      `SCLKS_OFS_SYS: begin
        rd_mux[`SCLKS_SYS_SEL_LSB +: 3] = sys_clk_sel_q;
        rd_mux[`SCLKS_SYS_SRC_BIT] = slow_src_sel_q;
        rd_mux[`SCLKS_SYS_HSKEEP_BIT] = hs_keep_on_halt_q;
        rd_mux[`SCLKS_SYS_LSKEEP_BIT] = ls_keep_on_halt_q;
      end
      `SCLKS_OFS_HSC: begin
        rd_mux[`SCLKS_HSC_FREQ_LSB +: 2] = hs_freq_sel_q;
        rd_mux[`SCLKS_HSC_FLAG_BIT] = hs_stable_flag_q;
        rd_mux[`SCLKS_HSC_EN_BIT] = hs_enable_q;
      end
      `SCLKS_OFS_XTC: begin
        rd_mux[`SCLKS_XTC_SP_BIT] = xtal_speedup_q;
        rd_mux[`SCLKS_XTC_FLAG_BIT] = xtal_stable_flag_q;
        rd_mux[`SCLKS_XTC_EN_BIT] = xtal_enable_q;
      end
      `SCLKS_OFS_STAT: begin
        rd_mux[2:0] = 3'(mode_q);
        rd_mux[3] = (sw_q != SCLKS_SW_RUN);
        rd_mux[6:4] = cur_sel_q;
        rd_mux[7] = cur_src_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sys_clk_sel_q <= `SCLKS_SEL_RST;
      slow_src_sel_q <= 1'b0;
      hs_keep_on_halt_q <= 1'b0;
      ls_keep_on_halt_q <= 1'b0;
    end else if (ce && wr_ack && avs_address == `SCLKS_OFS_SYS) begin
      sys_clk_sel_q <= avs_writedata[`SCLKS_SYS_SEL_LSB +: 3];
      slow_src_sel_q <= avs_writedata[`SCLKS_SYS_SRC_BIT];
      hs_keep_on_halt_q <= avs_writedata[`SCLKS_SYS_HSKEEP_BIT];
      ls_keep_on_halt_q <= avs_writedata[`SCLKS_SYS_LSKEEP_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hs_freq_sel_q <= `SCLKS_FREQ_RST;
      hs_enable_q <= `SCLKS_HSEN_RST;
    end else if (ce && wr_ack && avs_address == `SCLKS_OFS_HSC) begin
      hs_freq_sel_q <= avs_writedata[`SCLKS_HSC_FREQ_LSB +: 2];
      hs_enable_q <= avs_writedata[`SCLKS_HSC_EN_BIT];
    end
  end

  // The crystal drives the system clock only when slow mode and the
  // crystal source are both in force.
  assign xt_sys = (cur_sel_q == `SCLKS_SEL_SLOW) && cur_src_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xtal_enable_q <= 1'b0;
      xtal_speedup_q <= 1'b0;
    end else if (ce && wr_ack && avs_address == `SCLKS_OFS_XTC) begin
      xtal_enable_q <= avs_writedata[`SCLKS_XTC_EN_BIT];
      if (!xt_sys) begin
        xtal_speedup_q <= avs_writedata[`SCLKS_XTC_SP_BIT];
      end
    end
  end

  // --------------------------------------------------------------------
  // Oscillator sampling and divider
  // --------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hs_sync_q <= 3'h0;
      lr_sync_q <= 3'h0;
      xt_sync_q <= 3'h0;
    end else if (ce) begin
      hs_sync_q <= {hs_sync_q[1:0], hs_rc_osc};
      lr_sync_q <= {lr_sync_q[1:0], low_rc_osc};
      xt_sync_q <= {xt_sync_q[1:0], ext_low_xtal_osc};
    end
  end

  // Each divider bit toggles on a high-speed rising edge, giving /2../64.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_cnt_q <= 6'h00;
    end else if (ce && hs_sync_q[1] && !hs_sync_q[2]) begin
      div_cnt_q <= div_cnt_q + 6'h01;
    end
  end

  assign hs_taps = {div_cnt_q, hs_sync_q[1]};
  assign ls_lvl = slow_src_sel_q ? xt_sync_q[1] : lr_sync_q[1];
  assign cur_lvl = tap_level(cur_sel_q, cur_src_q, hs_taps,
                             xt_sync_q[1], lr_sync_q[1]);
  assign tgt_lvl = tap_level(sys_clk_sel_q, slow_src_sel_q, hs_taps,
                             xt_sync_q[1], lr_sync_q[1]);

  // --------------------------------------------------------------------
  // Glitch-free source switch
  // --------------------------------------------------------------------
  // A change waits for four rising edges of the current clock, then for
  // the current clock to have been low two samples and the target to be
  // low, so no output phase is shorter than two cycles.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sw_q <= SCLKS_SW_RUN;
      cur_sel_q <= `SCLKS_SEL_RST;
      cur_src_q <= 1'b0;
      edge_cnt_q <= 3'h0;
      cur_prev_q <= 1'b0;
    end else if (ce) begin
      cur_prev_q <= cur_lvl;
      unique case (sw_q)
        SCLKS_SW_RUN: begin
          edge_cnt_q <= 3'h0;
          if (sys_clk_sel_q != cur_sel_q || slow_src_sel_q != cur_src_q) begin
            sw_q <= SCLKS_SW_COUNT;
          end
        end
        SCLKS_SW_COUNT: begin
          if (cur_lvl && !cur_prev_q) begin
            edge_cnt_q <= edge_cnt_q + 3'h1;
            if (edge_cnt_q == 3'(`SCLKS_SWITCH_EDGES - 1)) begin
              sw_q <= SCLKS_SW_ALIGN;
            end
          end
        end
        SCLKS_SW_ALIGN: begin
          if (!cur_lvl && !cur_prev_q && !tgt_lvl) begin
            cur_sel_q <= sys_clk_sel_q;
            cur_src_q <= slow_src_sel_q;
            sw_q <= SCLKS_SW_RUN;
          end
        end
        default: begin
          sw_q <= SCLKS_SW_RUN;
        end
      endcase
    end
  end

  // The run gate only moves while the clock is low, so a halt never
  // shortens a high phase.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sys_run_q <= 1'b1;
      system_clk <= 1'b0;
    end else if (ce) begin
      if (!cur_lvl) begin
        sys_run_q <= !cpu_halt;
      end
      system_clk <= cur_lvl && sys_run_q;
    end
  end

  // --------------------------------------------------------------------
  // Operating mode and oscillator gating
  // --------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q <= SCLKS_MODE_FAST;
    end else if (ce) begin
      if (!cpu_halt) begin
        mode_q <= (sys_clk_sel_q == `SCLKS_SEL_SLOW) ? SCLKS_MODE_SLOW
                                                     : SCLKS_MODE_FAST;
      end else if (!hs_keep_on_halt_q && ls_keep_on_halt_q) begin
        mode_q <= SCLKS_MODE_IDLE_LOW_ONLY;
      end else if (hs_keep_on_halt_q && ls_keep_on_halt_q) begin
        mode_q <= SCLKS_MODE_IDLE_BOTH;
      end else if (hs_keep_on_halt_q) begin
        mode_q <= SCLKS_MODE_IDLE_HS_ONLY;
      end else begin
        mode_q <= SCLKS_MODE_SLEEP;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hs_on_q <= 1'b1;
      ls_on_q <= 1'b1;
      lr_on_q <= 1'b1;
    end else if (ce) begin
      unique case (mode_q)
        SCLKS_MODE_FAST: begin
          hs_on_q <= 1'b1;
          ls_on_q <= 1'b1;
          lr_on_q <= 1'b1;
        end
        SCLKS_MODE_SLOW: begin
          hs_on_q <= hs_enable_q;
          ls_on_q <= 1'b1;
          lr_on_q <= 1'b1;
        end
        SCLKS_MODE_IDLE_LOW_ONLY: begin
          hs_on_q <= 1'b0;
          ls_on_q <= 1'b1;
          lr_on_q <= 1'b1;
        end
        SCLKS_MODE_IDLE_BOTH: begin
          hs_on_q <= 1'b1;
          ls_on_q <= 1'b1;
          lr_on_q <= 1'b1;
        end
        SCLKS_MODE_IDLE_HS_ONLY: begin
          hs_on_q <= 1'b1;
          ls_on_q <= (cur_sel_q != `SCLKS_SEL_SLOW);
          lr_on_q <= 1'b1;
        end
        SCLKS_MODE_SLEEP: begin
          hs_on_q <= 1'b0;
          ls_on_q <= 1'b0;
          lr_on_q <= wdt_enable;
        end
        default: begin
          hs_on_q <= 1'b1;
          ls_on_q <= 1'b1;
          lr_on_q <= 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Stable flags
  // --------------------------------------------------------------------
  // The flag drops on enable or on any frequency write that changes the
  // field, and rises after the settling count.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hs_on_prev_q <= 1'b0;
      hs_stab_cnt_q <= 10'h000;
      hs_stable_flag_q <= 1'b0;
    end else if (ce) begin
      hs_on_prev_q <= hs_on_q;
      if (!hs_on_q || (hs_on_q && !hs_on_prev_q) ||
          (wr_ack && avs_address == `SCLKS_OFS_HSC &&
           avs_writedata[`SCLKS_HSC_FREQ_LSB +: 2] != hs_freq_sel_q)) begin
        hs_stab_cnt_q <= 10'h000;
        hs_stable_flag_q <= 1'b0;
      end else if (hs_stab_cnt_q == 10'(`SCLKS_HS_STAB_CYC - 1)) begin
        hs_stable_flag_q <= 1'b1;
      end else begin
        hs_stab_cnt_q <= hs_stab_cnt_q + 10'h001;
      end
    end
  end

  // The speed-up bit only picks the start-up count; once stable, clearing
  // it leaves the flag set, while xtal_speedup_en still follows the bit.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xt_stab_cnt_q <= 17'h00000;
      xtal_stable_flag_q <= 1'b0;
    end else if (ce) begin
      if (!xtal_enable_q) begin
        xt_stab_cnt_q <= 17'h00000;
        xtal_stable_flag_q <= 1'b0;
      end else if (!xtal_stable_flag_q) begin
        if (xt_stab_cnt_q >= 17'(xtal_speedup_q ? XT_SU_CYC - 1
                                                : XT_LP_CYC - 1)) begin
          xtal_stable_flag_q <= 1'b1;
        end else begin
          xt_stab_cnt_q <= xt_stab_cnt_q + 17'h00001;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Oscillator controls and peripheral clocks
  // --------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hs_osc_en <= 1'b1;
      hs_freq_code <= `SCLKS_FREQ_4M;
      low_rc_en <= 1'b1;
      xtal_osc_en <= 1'b0;
      xtal_speedup_en <= 1'b0;
      xtal_pins_osc <= 1'b0;
    end else if (ce) begin
      hs_osc_en <= hs_on_q;
      if (hs_freq_sel_q == `SCLKS_FREQ_4M_ALT) begin
        hs_freq_code <= `SCLKS_FREQ_4M;
      end else begin
        hs_freq_code <= hs_freq_sel_q;
      end
      low_rc_en <= lr_on_q;
      xtal_osc_en <= xtal_enable_q;
      xtal_speedup_en <= xtal_speedup_q;
      xtal_pins_osc <= xtal_enable_q || xt_sys;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      high_speed_clk <= 1'b0;
      hs_div_clk <= 6'h00;
      low_speed_clk <= 1'b0;
      wdt_clk <= 1'b0;
      tbase_clk <= 1'b0;
    end else if (ce) begin
      high_speed_clk <= hs_sync_q[1] && hs_on_q;
      hs_div_clk <= div_cnt_q & {6{hs_on_q}};
      low_speed_clk <= ls_lvl && ls_on_q;
      wdt_clk <= lr_sync_q[1] && lr_on_q;
      tbase_clk <= ls_lvl && ls_on_q;
    end
  end

endmodule

/* File: bench/sclks_top_monitor.sv */
`timescale 1ns/1ps
module sclks_top_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // State and generated clocks
  input wire logic cpu_halt,
  input wire logic wdt_enable,
  input wire logic [1:0] hs_freq_code,
  input wire logic low_rc_en,
  input wire logic xtal_osc_en,
  input wire logic xtal_pins_osc,
  input wire logic system_clk,
  input wire logic high_speed_clk
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic wr_ok;
  logic [7:0] sysc_q;
  logic [1:0] fexp_q;
  assign wr_ok = avs_write && !avs_waitrequest && ce;
  // Shadows of what software wrote, so checks can follow the settings.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sysc_q <= 8'h00;
    end else if (wr_ok && avs_address == 4'h0) begin
      sysc_q <= avs_writedata[7:0];
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fexp_q <= 2'h0;
    end else if (wr_ok && avs_address == 4'h4) begin
      fexp_q <= (avs_writedata[3:2] == 2'h3) ? 2'h0 : avs_writedata[3:2];
    end
  end
  a_wait_once:
    assert property (ce && (avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("no answer after one cycle");
  a_wait_single:
    assert property (ce && !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
  a_unmapped_zero:
    assert property (!avs_waitrequest && avs_read && avs_address[1:0] != 0
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_xtal_follow:
    assert property (wr_ok && avs_address == 4'h8
      |=> ##1 xtal_osc_en == $past(avs_writedata[0], 2))
      else $error("crystal enable not applied");
  a_pins_xtal:
    assert property (xtal_osc_en [*3] |-> xtal_pins_osc)
      else $error("crystal pins not owned while enabled");
  a_freq_decode:
    assert property ($changed(hs_freq_code) |-> hs_freq_code == fexp_q)
      else $error("frequency code differs from field");
  a_halt_sys_stop:
    assert property (cpu_halt [*2] ##0 !system_clk |=> !system_clk)
      else $error("system clock runs in halt");
  a_idle_hs_stop:
    assert property ((cpu_halt && sysc_q[1:0] == 2'b01 && sysc_q[7:5] != 3'h7)
      [*4] |-> !high_speed_clk) else $error("fast clock runs in idle");
  a_low_rc_osc_wdt_on:
    assert property (wdt_enable [*3] |-> low_rc_en)
      else $error("low RC off with watchdog on");
  a_no_runt:
    assert property ((ce && !cpu_halt) [*6] ##0 $changed(system_clk)
      |=> $stable(system_clk)) else $error("runt pulse on system clock");
endmodule
bind sclks_top sclks_top_monitor mon (.*);

/* File: bench/sclks_osc_model.sv */
`timescale 1ns/1ps
module sclks_osc_model (
  // Clock
  input wire logic clock,
  // Oscillator controls
  input wire logic hs_osc_en,
  input wire logic [1:0] hs_freq_code,
  input wire logic low_rc_en,
  input wire logic xtal_osc_en,
  input wire logic xtal_speedup_en,
  // Oscillator waveforms
  output logic hs_rc_osc,
  output logic low_rc_osc,
  output logic ext_low_xtal_osc
);
  // Rates are scaled far down so runs stay short.
  int hs_n = 0;
  int lr_n = 0;
  int xt_n = 0;
  int xt_up = 0;
  initial begin
    hs_rc_osc = 1'b0;
    low_rc_osc = 1'b0;
    ext_low_xtal_osc = 1'b0;
  end
  // Half periods 4, 3 and 2 cycles for the three codes
  always @(posedge clock) begin
    if (!hs_osc_en) begin
      hs_rc_osc <= 1'b0;
      hs_n <= 0;
    end else if (hs_n + 1 >= ((hs_freq_code == 2'h2) ? 2 :
                 (hs_freq_code == 2'h1) ? 3 : 4)) begin
      hs_rc_osc <= ~hs_rc_osc;
      hs_n <= 0;
    end else begin
      hs_n <= hs_n + 1;
    end
  end
  // Low RC half period 7, crystal half period 9
  always @(posedge clock) begin
    if (!low_rc_en) begin
      low_rc_osc <= 1'b0;
      lr_n <= 0;
    end else if (lr_n >= 6) begin
      low_rc_osc <= ~low_rc_osc;
      lr_n <= 0;
    end else begin
      lr_n <= lr_n + 1;
    end
  end
  // Low power lengthens the silent start; clearing speed-up after start pauses the crystal until 60
  always @(posedge clock) begin
    if (!xtal_osc_en) begin
      ext_low_xtal_osc <= 1'b0;
      xt_up <= 0;
      xt_n <= 0;
    end else if (xt_up < (xtal_speedup_en ? 30 : 60)) begin
      xt_up <= xt_up + 1;
    end else if (xt_n >= 8) begin
      ext_low_xtal_osc <= ~ext_low_xtal_osc;
      xt_n <= 0;
    end else begin
      xt_n <= xt_n + 1;
    end
  end
endmodule

/* File: bench/sclks_top_tb.sv */
`timescale 1ns/1ps
module sclks_top_tb import sclks_pkg::*; ;
  logic clock, rst, ce, avs_read, avs_write, avs_waitrequest;
  logic cpu_halt, wdt_enable, hs_rc_osc, low_rc_osc, ext_low_xtal_osc;
  logic hs_osc_en, low_rc_en, xtal_osc_en, xtal_speedup_en, xtal_pins_osc;
  logic system_clk, high_speed_clk, low_speed_clk, wdt_clk, tbase_clk;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0] hs_freq_code;
  logic [5:0] hs_div_clk;
  int miscompares = 0;
  int samples_checked = 0;
  integer seed = 32'hed139e90;
  always #10 clock = ~clock;
  sclks_top #(.XT_SU_CYC(20), .XT_LP_CYC(40)) dut (.*);
  sclks_osc_model osc (.*);
  task automatic end_sim;
    $display("Compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic timed_out;
    miscompares++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    end_sim();
  endtask
  // One access; request held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) timed_out();
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic poll(input logic [3:0] a, input logic [7:0] m, v);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 8'h00);
      n++;
    end while ((rd[7:0] & m) !== v && n < 1500);
    if ((rd[7:0] & m) !== v) timed_out();
  endtask
  task automatic rises(input int win, output int c);
    logic p;
    c = 0;
    p = system_clk;
    repeat (win) begin
      @(posedge clock);
      if (system_clk === 1'b1 && p === 1'b0) c++;
      p = system_clk;
    end
  endtask
  function automatic logic [1:0] exp_freq(input logic [1:0] f);
    return (f == 2'h3) ? 2'h0 : f;
  endfunction
  function automatic logic [2:0] exp_mode(input logic h, input logic [1:0] k,
                                          input logic [2:0] s);
    if (!h) return (s == 3'h7) ? SCLKS_MODE_SLOW : SCLKS_MODE_FAST;
    case (k)
      2'b00: return SCLKS_MODE_SLEEP;
      2'b01: return SCLKS_MODE_IDLE_LOW_ONLY;
      2'b11: return SCLKS_MODE_IDLE_BOTH;
      default: return SCLKS_MODE_IDLE_HS_ONLY;
    endcase
  endfunction
  initial begin
    logic [2:0] s;
    logic [1:0] f;
    logic w;
    int c;
    clock = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    cpu_halt = 1'b0;
    wdt_enable = 1'b0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 8'h00);
    check(rd, 32'h0);
    bus(1'b0, 4'h4, 8'h00);
    check(rd, 32'h1);
    bus(1'b1, 4'h2, 8'($random(seed)));
    bus(1'b0, 4'h2, 8'h00);
    check(rd, 32'h0);
    $display("Test reset done");
    f = 2'($random(seed));
    for (int i = 0; i < 4; i++) begin
      f = f + 2'h1;
      bus(1'b1, 4'h4, {4'h0, f, 2'b01});
      bus(1'b0, 4'h4, 8'h00);
      check(32'(rd[1]), 32'h0);
      poll(4'h4, 8'h02, 8'h02);
      check(32'(hs_freq_code), 32'(exp_freq(f)));
    end
    // Leave the field at the 4 MHz factory setting
    bus(1'b1, 4'h4, 8'h01);
    poll(4'h4, 8'h02, 8'h02);
    $display("Test frequency done");
    s = 3'($random(seed));
    for (int i = 0; i < 8; i++) begin
      s = s + 3'h1;
      bus(1'b1, 4'h0, {s, 5'h00});
      poll(4'hC, 8'hF8, {1'b0, s, 4'h0});
      check(32'(rd[2:0]), 32'(exp_mode(1'b0, 2'b00, s)));
      rises((s == 3'h7) ? 56 : (32 << s), c);
      check(32'(c), 32'h4);
    end
    // Slow mode first: only there does the hs enable bit stop the fast oscillator.
    bus(1'b1, 4'h0, 8'hE0);
    poll(4'hC, 8'hF8, 8'h70);
    ce <= 1'b0;
    @(posedge clock);
    rises(16, c);
    check(32'(c), 32'h0);
    ce <= 1'b1;
    bus(1'b1, 4'h4, 8'h00);
    repeat (4) @(posedge clock);
    check(32'(hs_osc_en), 32'h0);
    bus(1'b1, 4'h4, 8'h01);
    poll(4'h4, 8'h02, 8'h02);
    check(32'(hs_osc_en), 32'h1);
    $display("Test select done");
    bus(1'b1, 4'h8, 8'h05);
    bus(1'b0, 4'h8, 8'h00);
    check(32'(rd[1]), 32'h0);
    check(32'(xtal_speedup_en), 32'h1);
    poll(4'h8, 8'h02, 8'h02);
    bus(1'b1, 4'h0, 8'hE4);
    poll(4'hC, 8'hF8, 8'hF0);
    rises(72, c);
    check(32'(c), 32'h4);
    bus(1'b1, 4'h8, 8'h01);
    bus(1'b0, 4'h8, 8'h00);
    check(32'(rd[2:0]), 32'h7);
    bus(1'b1, 4'h0, 8'h00);
    poll(4'hC, 8'hF8, 8'h00);
    bus(1'b1, 4'h8, 8'h01);
    bus(1'b0, 4'h8, 8'h00);
    check(32'(rd[2:0]), 32'h3);
    check(32'(xtal_speedup_en), 32'h0);
    bus(1'b1, 4'h8, 8'h00);
    repeat (4) @(posedge clock);
    check(32'(xtal_pins_osc), 32'h0);
    $display("Test crystal done");
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 4'h0, {6'h00, 2'(k)});
      w = 1'($random(seed));
      wdt_enable <= w;
      cpu_halt <= 1'b1;
      repeat (8) @(posedge clock);
      bus(1'b0, 4'hC, 8'h00);
      check(32'(rd[2:0]), 32'(exp_mode(1'b1, 2'(k), 3'h0)));
      check(32'(low_rc_en), (k == 0) ? 32'(w) : 32'h1);
      if (k < 2) check(32'({high_speed_clk, hs_div_clk}), 32'h0);
      if (k == 0) check(32'({low_speed_clk, tbase_clk}), 32'h0);
      rises(16, c);
      check(32'(c), 32'h0);
      cpu_halt <= 1'b0;
      repeat (8) @(posedge clock);
    end
    $display("Test halt done");
    end_sim();
  end
endmodule
